// >>> hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk, // 200 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic [stepper_pkg::SYNC_WIDTH-1:0] pins, // Raw pin levels
	output logic [stepper_pkg::SYNC_WIDTH-1:0] synced // Two-stage synchronised levels
);

	stepper_pkg::sync_s q;
	stepper_pkg::sync_s d;

	always_comb begin
		d = q;
		d.stage1 = pins;
		d.stage2 = q.stage1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign synced = q.stage2;

endmodule

// >>> hdl/stepper_phase_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Edge-select high: one step per step-clock rising edge, falling edges ignored.
// - Edge-select low: one step on every rising and every falling edge.
// - Excitation-select low gives full-step, high gives half-step excitation.
// - Direction low steps forward, high steps in reverse order.
// - Sequencer held in reset while system reset input is low.
// - On reset release pattern starts at phase A plus second-phase complement.
// - Enable low forces all four drive outputs off.
// - Enable low freezes sequencing; system reset and fault latching still act.
// - Open-drain fault output pulled low on overcurrent or overheat.
// - Faults latch outputs off until power-on or system reset pulse.
module stepper_phase_sequencer (
	input wire logic clk, // 200 MHz clock
	input wire logic rst_n, // Power-on reset, async, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic step_clock_in, // Step clock pin
	input wire logic excitation_select, // Low full-step, high half-step
	input wire logic edge_select, // High rising only, low both edges
	input wire logic direction_in, // Low forward, high reverse
	input wire logic enable_in, // Drive enable, active high
	input wire logic system_reset_n, // System reset pin, active low
	input wire logic overcurrent_det, // Overcurrent detector level
	input wire logic overheat_det, // Overheat detector level
	output logic phase_a_out, // Phase A drive
	output logic first_phase_complement_out, // Phase A complement drive
	output logic phase_b_out, // Phase B drive
	output logic second_phase_complement_out, // Phase B complement drive
	output logic fault_pin_out, // Open-drain fault data, always low
	output logic fault_pin_oe_n, // Low while fault pulls the pin low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o // Wishbone acknowledge
);

	logic [stepper_pkg::SYNC_WIDTH-1:0] raw;
	logic [stepper_pkg::SYNC_WIDTH-1:0] s;
	stepper_pkg::seq_s q;
	stepper_pkg::seq_s d;
	logic rise;
	logic fall;
	logic step_edge;
	logic [2:0] delta;
	logic bus_req;

	// Order A, A complement, B, B complement; pairs on even positions
	function automatic logic [3:0] phase_pattern(input logic [2:0] pos);
		logic [3:0] pat;
		pat = 4'h0;
		case (pos)
			3'h0: pat = 4'b1001;
			3'h1: pat = 4'b1000;
			3'h2: pat = 4'b1010;
			3'h3: pat = 4'b0010;
			3'h4: pat = 4'b0110;
			3'h5: pat = 4'b0100;
			3'h6: pat = 4'b0101;
			3'h7: pat = 4'b0001;
			default: pat = 4'h0;
		endcase
		return pat;
	endfunction

	// Wraps modulo eight, so a half step in reverse from position 0 lands on 7
	function automatic logic [2:0] next_pos(input logic [2:0] pos, input logic [2:0] delta_in, input logic reverse);
		logic [2:0] np;
		np = pos + delta_in;
		if (reverse) begin
			np = pos - delta_in;
		end
		return np;
	endfunction

	// Status snapshot; mode bits are the synchronised levels, not the raw pins
	function automatic logic [31:0] status_word(
		input stepper_pkg::seq_s st,
		input logic [stepper_pkg::SYNC_WIDTH-1:0] lv
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[stepper_pkg::STATUS_POS_LSB +: 3] = st.pos;
		w[stepper_pkg::STATUS_FAULT_BIT] = st.fault;
		w[stepper_pkg::STATUS_DRIVE_LSB +: 4] = st.drive;
		w[stepper_pkg::STATUS_OC_BIT] = st.oc_seen;
		w[stepper_pkg::STATUS_OT_BIT] = st.ot_seen;
		w[stepper_pkg::STATUS_EXC_BIT] = lv[stepper_pkg::IN_EXCITATION];
		w[stepper_pkg::STATUS_EDGE_BIT] = lv[stepper_pkg::IN_EDGE];
		w[stepper_pkg::STATUS_DIR_BIT] = lv[stepper_pkg::IN_DIRECTION];
		w[stepper_pkg::STATUS_EN_BIT] = lv[stepper_pkg::IN_ENABLE];
		return w;
	endfunction

	assign raw[stepper_pkg::IN_STEP_CLOCK] = step_clock_in;
	assign raw[stepper_pkg::IN_EXCITATION] = excitation_select;
	assign raw[stepper_pkg::IN_EDGE] = edge_select;
	assign raw[stepper_pkg::IN_DIRECTION] = direction_in;
	assign raw[stepper_pkg::IN_ENABLE] = enable_in;
	assign raw[stepper_pkg::IN_SYS_RESET_N] = system_reset_n;
	assign raw[stepper_pkg::IN_OVERCURRENT] = overcurrent_det;
	assign raw[stepper_pkg::IN_OVERHEAT] = overheat_det;

	pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pins(raw),
		.synced(s)
	);

	assign rise = s[stepper_pkg::IN_STEP_CLOCK] & ~q.clk_prev;
	assign fall = ~s[stepper_pkg::IN_STEP_CLOCK] & q.clk_prev;
	assign step_edge = rise | (~s[stepper_pkg::IN_EDGE] & fall);

	// Full-step from an odd (single-phase) state lands on the next pair
	always_comb begin
		if (!s[stepper_pkg::IN_EXCITATION] && !q.pos[0]) begin
			delta = 3'h2;
		end else begin
			delta = 3'h1;
		end
	end

	assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;

	always_comb begin
		d = q;
		d.ack = 1'b0;
		if (!s[stepper_pkg::IN_SYS_RESET_N]) begin
			// Edge tracker follows the pin so release gives no false step
			d.pos = stepper_pkg::POS_INITIAL;
			d.fault = 1'b0;
			d.clk_prev = s[stepper_pkg::IN_STEP_CLOCK];
		end else begin
			if (s[stepper_pkg::IN_OVERCURRENT] || s[stepper_pkg::IN_OVERHEAT]) begin
				d.fault = 1'b1;
			end
			if (s[stepper_pkg::IN_ENABLE]) begin
				d.clk_prev = s[stepper_pkg::IN_STEP_CLOCK];
				if (step_edge && !q.fault) begin
					d.pos = next_pos(q.pos, delta, s[stepper_pkg::IN_DIRECTION]);
					d.steps = q.steps + 16'h0001;
				end
			end
		end
		if (s[stepper_pkg::IN_OVERCURRENT]) begin
			d.oc_seen = 1'b1;
		end
		if (s[stepper_pkg::IN_OVERHEAT]) begin
			d.ot_seen = 1'b1;
		end
		// Position is kept while disabled, only the drive is cut
		if (s[stepper_pkg::IN_ENABLE] && q.run && !d.fault) begin
			d.drive = phase_pattern(d.pos);
		end else begin
			d.drive = 4'h0;
		end
		if (bus_req) begin
			d.ack = 1'b1;
			d.rdata = 32'h0000_0000;
			if (wb_adr_i == stepper_pkg::CONTROL_OFFSET) begin
				d.rdata[stepper_pkg::CONTROL_RUN_BIT] = q.run;
				if (wb_we_i && wb_sel_i[0]) begin
					d.run = wb_dat_i[stepper_pkg::CONTROL_RUN_BIT];
				end
			end else if (wb_adr_i == stepper_pkg::STATUS_OFFSET) begin
				d.rdata = status_word(q, s);
				// Write-one clears the sticky detector history; a new event wins
				if (wb_we_i && wb_sel_i[1]) begin
					if (wb_dat_i[stepper_pkg::STATUS_OC_BIT] && !s[stepper_pkg::IN_OVERCURRENT]) begin
						d.oc_seen = 1'b0;
					end
					if (wb_dat_i[stepper_pkg::STATUS_OT_BIT] && !s[stepper_pkg::IN_OVERHEAT]) begin
						d.ot_seen = 1'b0;
					end
				end
			end else if (wb_adr_i == stepper_pkg::STEP_COUNT_OFFSET) begin
				d.rdata[15:0] = q.steps;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= stepper_pkg::SEQ_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	assign phase_a_out = q.drive[3];
	assign first_phase_complement_out = q.drive[2];
	assign phase_b_out = q.drive[1];
	assign second_phase_complement_out = q.drive[0];
	assign fault_pin_out = 1'b0;
	assign fault_pin_oe_n = ~q.fault;
	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;

endmodule

// >>> hdl/stepper_pkg.sv
package stepper_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] STEP_COUNT_OFFSET = 8'h08;

	// Control register fields
	localparam int CONTROL_RUN_BIT = 0;
	localparam logic CONTROL_RUN_RESET = 1'b1;

	// Status register fields
	localparam int STATUS_POS_LSB = 0;
	localparam int STATUS_FAULT_BIT = 3;
	localparam int STATUS_DRIVE_LSB = 4;
	localparam int STATUS_OC_BIT = 8;
	localparam int STATUS_OT_BIT = 9;
	localparam int STATUS_EXC_BIT = 10;
	localparam int STATUS_EDGE_BIT = 11;
	localparam int STATUS_DIR_BIT = 12;
	localparam int STATUS_EN_BIT = 13;

	// Synchronised input bit positions
	localparam int SYNC_WIDTH = 8;
	localparam int IN_STEP_CLOCK = 0;
	localparam int IN_EXCITATION = 1;
	localparam int IN_EDGE = 2;
	localparam int IN_DIRECTION = 3;
	localparam int IN_ENABLE = 4;
	localparam int IN_SYS_RESET_N = 5;
	localparam int IN_OVERCURRENT = 6;
	localparam int IN_OVERHEAT = 7;

	// Sequence position after reset: phase A with second-phase complement
	localparam logic [2:0] POS_INITIAL = 3'h0;

	// Controller-side timing, kept for reference by the environment
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MODE_GUARD_PS = 5000000;
	localparam int MODE_GUARD_CYCLES = (MODE_GUARD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DIR_GUARD_PS = 6250000;
	localparam int DIR_GUARD_CYCLES = (DIR_GUARD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_TO_CLOCK_PS = 10000000;
	localparam int RESET_TO_CLOCK_CYCLES = (RESET_TO_CLOCK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef struct packed {
		logic [2:0] pos;
		logic [3:0] drive;
		logic fault;
		logic oc_seen;
		logic ot_seen;
		logic clk_prev;
		logic run;
		logic [15:0] steps;
		logic ack;
		logic [31:0] rdata;
	} seq_s;

	localparam seq_s SEQ_RESET = '{
		pos: POS_INITIAL,
		drive: 4'h0,
		fault: 1'b0,
		oc_seen: 1'b0,
		ot_seen: 1'b0,
		clk_prev: 1'b0,
		run: CONTROL_RUN_RESET,
		steps: 16'h0000,
		ack: 1'b0,
		rdata: 32'h0000_0000
	};

	typedef struct packed {
		logic [SYNC_WIDTH-1:0] stage1;
		logic [SYNC_WIDTH-1:0] stage2;
	} sync_s;

endpackage

// >>> test/step_src.sv
`timescale 1ns/1ps
module step_src (
	input wire logic clk, // Clock
	input wire logic req, // Toggle request
	output logic step_clk // Step clock
);
	initial step_clk = 1'b0;
	// Static between requests; spacing comes from the bench
	always @(posedge clk) if (req) step_clk <= ~step_clk;
endmodule

// >>> test/stepper_phase_sequencer_bench.sv
`timescale 1ns/1ps
module stepper_phase_sequencer_bench;
	logic clk, rst_n, ce, step_clock_in, excitation_select, edge_select, direction_in, enable_in, req;
	logic system_reset_n, overcurrent_det, overheat_det, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic phase_a_out, first_phase_complement_out, phase_b_out, second_phase_complement_out;
	logic fault_pin_out, fault_pin_oe_n;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] pat [8] = '{4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
	int errors = 0, num_checks = 0, p = 0, n = 0;
	wire [3:0] drv = {phase_a_out, first_phase_complement_out, phase_b_out, second_phase_complement_out};
	stepper_phase_sequencer dut (.*);
	step_src ctl (.clk(clk), .req(req), .step_clk(step_clock_in));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task results;
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task ck(input logic [31:0] s, input logic [31:0] e, input string nm);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
		i = 0;
		// Ack is looked at mid-cycle, clear of the edge that launches it
		do begin
			@(posedge clk);
			@(negedge clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			results;
		end
		@(posedge clk);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk);
	endtask
	// Guard on both sides keeps mode and direction clear of every edge
	task mv(input int d, input string nm);
		int g;
		// Double-edge stepping needs 20 us pulses, so its halves are stretched
		g = edge_select ? stepper_pkg::DIR_GUARD_CYCLES : 2 * stepper_pkg::DIR_GUARD_CYCLES;
		repeat (g) @(posedge clk);
		req <= 1;
		@(posedge clk) req <= 0;
		repeat (g) @(posedge clk);
		p = (p + d + 8) % 8;
		if (d != 0) n++;
		ck(drv, enable_in ? pat[p] : 4'h0, nm);
	endtask
	task t_full;
		repeat (4) begin
			mv(2, "full fwd");
			mv(0, "fall ignored");
		end
	endtask
	task t_half;
		{excitation_select, direction_in, edge_select} <= 3'b110;
		@(posedge clk);
		repeat (5) mv(-1, "half rev");
	endtask
	task t_mode;
		{excitation_select, direction_in} <= 2'b00;
		mv(1, "mode odd");
		mv(2, "mode even");
	endtask
	task t_enable;
		enable_in <= 0;
		repeat (8) @(posedge clk);
		ck(drv, 4'h0, "disabled");
		mv(0, "frozen a");
		mv(0, "frozen b");
		enable_in <= 1;
		repeat (10) @(posedge clk);
		ck(drv, pat[p], "resume");
	endtask
	task t_bus;
		wb(0, stepper_pkg::STATUS_OFFSET, 0);
		ck(rd[2:0], p[2:0], "position");
		wb(0, stepper_pkg::STEP_COUNT_OFFSET, 0);
		ck(rd[15:0], n[15:0], "step count");
		wb(0, 8'h20, 32'h0000_0000);
		ck(rd, 32'h0000_0000, "unmapped");
		wb(0, stepper_pkg::CONTROL_OFFSET, 0);
		ck(rd[0], 1'b1, "run reset");
		wb(1, stepper_pkg::CONTROL_OFFSET, 32'h0000_0000);
		ck(drv, 4'h0, "run off");
		wb(1, stepper_pkg::CONTROL_OFFSET, 32'h0000_0001);
		ck(drv, pat[p], "run on");
	endtask
	task t_fault;
		int k;
		for (k = 0; k < 2; k++) begin
			{overheat_det, overcurrent_det} <= k ? 2'b10 : 2'b01;
			repeat (8) @(posedge clk);
			{overheat_det, overcurrent_det} <= 2'b00;
			repeat (8) @(posedge clk);
			ck(fault_pin_oe_n, 1'b0, "fault");
			ck(fault_pin_out, 1'b0, "fault data");
			ck(drv, 4'h0, "fault off");
			system_reset_n <= 0;
			repeat (8) @(posedge clk);
			ck(fault_pin_oe_n, 1'b1, "fault clear");
			ck(drv, 4'h9, "sys reset");
			system_reset_n <= 1;
			repeat (stepper_pkg::RESET_TO_CLOCK_CYCLES) @(posedge clk);
			p = 0;
			mv(2, "after reset");
		end
	endtask
	initial begin
		{rst_n, ce, excitation_select, direction_in, enable_in, system_reset_n} = 6'b010011;
		{edge_select, overcurrent_det, overheat_det, req, wb_cyc_i, wb_stb_i, wb_we_i} = 7'b1000000;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		repeat (stepper_pkg::RESET_TO_CLOCK_CYCLES) @(posedge clk);
		ck(drv, 4'h9, "init");
		t_full;
		t_half;
		t_mode;
		t_enable;
		t_bus;
		t_fault;
		results;
	end
endmodule
bind stepper_phase_sequencer stepper_sva chk (.*);

// >>> test/stepper_sva.sv
`timescale 1ns/1ps
module stepper_sva (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic ce, // Enable
	input wire logic step_clock_in, // Step
	input wire logic edge_select, // Edges
	input wire logic enable_in, // Drive on
	input wire logic system_reset_n, // Sys reset
	input wire logic overcurrent_det, // Det
	input wire logic overheat_det, // Det
	input wire logic wb_cyc_i, // Bus
	input wire logic phase_a_out, // A
	input wire logic first_phase_complement_out, // A comp
	input wire logic phase_b_out, // B
	input wire logic second_phase_complement_out, // B comp
	input wire logic fault_pin_oe_n // Fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [3:0] drv = {phase_a_out, first_phase_complement_out, phase_b_out, second_phase_complement_out};
	// Windows are long enough to cover the input synchronisers
	wire q = ce && enable_in && system_reset_n && !wb_cyc_i && fault_pin_oe_n && !overcurrent_det && !overheat_det;
	drive_off_a: assert property ((ce && !enable_in)[*4] |-> drv == 4'h0) else $error("drive while off");
	pair_ok_a: assert property (!(drv[3] && drv[2]) && !(drv[1] && drv[0])) else $error("bad pair");
	fault_set_a: assert property ((ce && system_reset_n && overcurrent_det)[*6] |-> !fault_pin_oe_n && drv == 4'h0)
		else $error("no fault");
	fault_hold_a: assert property ((ce && system_reset_n && !fault_pin_oe_n)[*3] |=> !fault_pin_oe_n)
		else $error("fault lost");
	hold_a: assert property ((q && $stable(step_clock_in))[*8] |=> $stable(drv)) else $error("drift");
	rise_only_a: assert property ((q && edge_select && $stable(step_clock_in))[*4] ##1 ($fell(step_clock_in) && q
		&& edge_select) ##1 (q && edge_select && $stable(step_clock_in))[*5] |-> drv == $past(drv, 5))
		else $error("fall stepped");
	both_edge_a: assert property ((q && !edge_select && $stable(step_clock_in))[*4] ##1 ($fell(step_clock_in) && q
		&& drv != 4'h0) ##1 (q && $stable(step_clock_in))[*5] |-> drv != $past(drv, 5))
		else $error("fall missed");
	sys_reset_a: assert property ((ce && enable_in && !system_reset_n && !wb_cyc_i)[*6] |-> drv == 4'h9)
		else $error("bad init");
	cover property ($fell(fault_pin_oe_n));
	cover property ($rose(phase_b_out));
	cover property (!system_reset_n ##1 system_reset_n);
endmodule
